// [rtl/frsp_serial_port.sv]
// Fixed rate serial port: double buffered transmitter, receiver, status
// Overview of operation
// - The line runs only at 9600 baud, 8 data bits, odd parity, 1 stop.
// - Bit rate and interval timer rate both come from the timer input.
// - All port status sits in the low byte of the system status word.
// - A holding buffer keeps the next character while a shifter sends.
// - Status bit 1 is low while shifting and high once the stop is out.
// - Status bit 2 is high whenever the holding buffer can take a byte.
// - A transmit write loads only the low byte of the written word.
// - A load clears bit 2, moves to the shifter, then bit 1 low, 2 high.
// - A reload during shifting follows on with no idle gap.
// - A receive read returns the eight data bits in the low byte.
// - Status bit 7 is the OR of overrun, framing and parity errors.
// - Bits 6, 5 and 4 give overrun, framing and parity for the buffer.
// - Status bit 0 rises when a whole character lands in the buffer.
// - Status bit 3 mirrors the console request input level.
`timescale 1ns/1ps
`default_nettype none
module frsp_serial_port #(
    parameter int TIMER_CLK_HZ = frsp_pkg::TIMER_CLK_HZ_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Rate input and interval timer tick
    input wire logic timer_rate_clock_in,
    output logic interval_timer_tick,
    // Output instruction to the transmit buffer
    input wire logic tx_buf_wr,
    input wire logic [15:0] tx_buf_wdata,
    // Input instruction from the receive buffer
    input wire logic rx_buf_rd,
    output logic [15:0] serial_receive_buffer,
    // Status word
    output logic [15:0] system_status,
    // Discrete and serial pins
    input wire logic console_request,
    input wire logic serial_rx,
    output logic serial_tx
);
    frsp_tick_if ticks ();

    frsp_rate_div #(.TIMER_CLK_HZ(TIMER_CLK_HZ)) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .timer_rate_clock_in(timer_rate_clock_in),
        .ticks(ticks)
    );

    function automatic logic [9:0] tx_frame(input logic [7:0] d);
        tx_frame = {1'b1, ~^d, d};
    endfunction

    // ============================================================
    // Transmitter
    frsp_pkg::frsp_tx_e tx_state, next_tx_state;
    logic [7:0] hold_buf, next_hold_buf;
    logic hold_full, next_hold_full;
    logic [9:0] tx_sh, next_tx_sh;
    logic [3:0] tx_bit, next_tx_bit;
    logic [3:0] tx_os, next_tx_os;
    logic tx_line, next_tx_line;
    logic tx_accept;
    logic tx_load;

    always_comb begin
        next_tx_state = tx_state;
        next_hold_buf = hold_buf;
        next_hold_full = hold_full;
        next_tx_sh = tx_sh;
        next_tx_bit = tx_bit;
        next_tx_os = tx_os;
        next_tx_line = tx_line;
        tx_load = 1'b0;
        // Writes while the buffer is full are dropped; software polls first
        tx_accept = tx_buf_wr & ~hold_full;
        if (tx_accept) begin
            next_hold_buf = tx_buf_wdata[7:0];
            next_hold_full = 1'b1;
        end
        case (tx_state)
            frsp_pkg::TX_IDLE: begin
                next_tx_line = 1'b1;
                // Loading on a tick keeps the start bit a full bit long
                tx_load = hold_full & ticks.os_tick;
            end
            frsp_pkg::TX_SHIFT: begin
                if (ticks.os_tick) begin
                    if (tx_os == frsp_pkg::OS_LAST) begin
                        next_tx_os = 4'h0;
                        if (tx_bit == frsp_pkg::TX_LAST_BIT) begin
                            tx_load = hold_full;
                            next_tx_line = 1'b1;
                            next_tx_state = frsp_pkg::TX_IDLE;
                        end else begin
                            next_tx_line = tx_sh[0];
                            next_tx_sh = {1'b1, tx_sh[9:1]};
                            next_tx_bit = tx_bit + 4'h1;
                        end
                    end else begin
                        next_tx_os = tx_os + 4'h1;
                    end
                end
            end
            default: begin
                next_tx_state = frsp_pkg::TX_IDLE;
            end
        endcase
        if (tx_load) begin
            next_tx_sh = tx_frame(hold_buf);
            next_hold_full = 1'b0;
            next_tx_line = 1'b0;
            next_tx_bit = 4'h0;
            next_tx_os = 4'h0;
            next_tx_state = frsp_pkg::TX_SHIFT;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state <= frsp_pkg::TX_IDLE;
            hold_buf <= 8'h00;
            hold_full <= 1'b0;
            tx_sh <= 10'h3FF;
            tx_bit <= 4'h0;
            tx_os <= 4'h0;
            tx_line <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            hold_buf <= next_hold_buf;
            hold_full <= next_hold_full;
            tx_sh <= next_tx_sh;
            tx_bit <= next_tx_bit;
            tx_os <= next_tx_os;
            tx_line <= next_tx_line;
        end
    end

    // ============================================================
    // Receiver
    frsp_pkg::frsp_rx_e rx_state, next_rx_state;
    logic [3:0] rx_os, next_rx_os;
    logic [3:0] rx_bit, next_rx_bit;
    logic [9:0] rx_sh, next_rx_sh;
    logic [7:0] rx_buf, next_rx_buf;
    logic dr, oe, fe, pe;
    logic next_dr, next_oe, next_fe, next_pe;
    logic [15:0] next_rxbuf_out;
    logic rx_done;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_os = rx_os;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_buf = rx_buf;
        next_dr = dr;
        next_oe = oe;
        next_fe = fe;
        next_pe = pe;
        next_rxbuf_out = serial_receive_buffer;
        rx_done = 1'b0;
        case (rx_state)
            frsp_pkg::RX_IDLE: begin
                // Hunt only once the line is high again, so a low stop
                // bit is not taken for the next start bit
                if (serial_rx) begin
                    next_rx_bit = 4'h0;
                end else if (ticks.os_tick && rx_bit == 4'h0) begin
                    next_rx_os = 4'h1;
                    next_rx_state = frsp_pkg::RX_START;
                end
            end
            frsp_pkg::RX_START: begin
                if (ticks.os_tick) begin
                    if (rx_os == frsp_pkg::SAMPLE_POINT) begin
                        next_rx_os = 4'h0;
                        next_rx_bit = 4'h0;
                        // A start bit gone high by mid-bit was a glitch
                        next_rx_state = serial_rx ? frsp_pkg::RX_IDLE :
                            frsp_pkg::RX_BITS;
                    end else begin
                        next_rx_os = rx_os + 4'h1;
                    end
                end
            end
            frsp_pkg::RX_BITS: begin
                if (ticks.os_tick) begin
                    if (rx_os == frsp_pkg::OS_LAST) begin
                        next_rx_os = 4'h0;
                        next_rx_sh = {serial_rx, rx_sh[9:1]};
                        next_rx_bit = rx_bit + 4'h1;
                        if (rx_bit == frsp_pkg::RX_LAST_BIT) begin
                            rx_done = 1'b1;
                            next_rx_state = frsp_pkg::RX_IDLE;
                        end
                    end else begin
                        next_rx_os = rx_os + 4'h1;
                    end
                end
            end
            default: begin
                next_rx_state = frsp_pkg::RX_IDLE;
            end
        endcase
        if (rx_buf_rd) begin
            next_rxbuf_out = {8'h00, rx_buf};
            next_dr = 1'b0;
            next_oe = 1'b0;
            next_fe = 1'b0;
            next_pe = 1'b0;
        end
        // A new character wins over a read in the same cycle
        if (rx_done) begin
            next_rx_buf = next_rx_sh[7:0];
            next_dr = 1'b1;
            next_oe = dr & ~rx_buf_rd;
            next_fe = ~next_rx_sh[9];
            next_pe = ~^next_rx_sh[8:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_state <= frsp_pkg::RX_IDLE;
            rx_os <= 4'h0;
            rx_bit <= 4'h0;
            rx_sh <= 10'h000;
            rx_buf <= 8'h00;
            dr <= 1'b0;
            oe <= 1'b0;
            fe <= 1'b0;
            pe <= 1'b0;
            serial_receive_buffer <= frsp_pkg::RXBUF_RST;
        end else begin
            rx_state <= next_rx_state;
            rx_os <= next_rx_os;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_buf <= next_rx_buf;
            dr <= next_dr;
            oe <= next_oe;
            fe <= next_fe;
            pe <= next_pe;
            serial_receive_buffer <= next_rxbuf_out;
        end
    end

    // ============================================================
    // Status word and pins; status lags the flags by one cycle
    logic [15:0] next_status;

    always_comb begin
        next_status = 16'h0000;
        next_status[frsp_pkg::ST_DR] = dr;
        next_status[frsp_pkg::ST_TE] = tx_state == frsp_pkg::TX_IDLE;
        next_status[frsp_pkg::ST_TBE] = ~hold_full;
        next_status[frsp_pkg::ST_CONSOLE] = console_request;
        next_status[frsp_pkg::ST_PE] = pe;
        next_status[frsp_pkg::ST_FE] = fe;
        next_status[frsp_pkg::ST_OE] = oe;
        next_status[frsp_pkg::ST_RE] = oe | fe | pe;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            system_status <= frsp_pkg::STATUS_RST;
            serial_tx <= 1'b1;
            interval_timer_tick <= 1'b0;
        end else begin
            system_status <= next_status;
            serial_tx <= tx_line;
            interval_timer_tick <= ticks.timer_tick;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_accept;
        tx_buf_wr && !hold_full;
    endsequence
    sequence s_frame_start;
        tx_state == frsp_pkg::TX_IDLE && hold_full && ticks.os_tick;
    endsequence

    a_write_fills_buf: assert property (
        s_accept |=> hold_full && hold_buf == $past(tx_buf_wdata[7:0]))
        else $error("accepted write did not fill holding buffer");
    a_idle_loads: assert property (
        s_frame_start |=> tx_state == frsp_pkg::TX_SHIFT && !hold_full
            ##1 !system_status[frsp_pkg::ST_TE]
            && system_status[frsp_pkg::ST_TBE])
        else $error("idle transmitter did not load shifter");
    a_start_bit_low: assert property (
        s_frame_start |=> ##1 !serial_tx)
        else $error("frame did not open with a low start bit");
    a_back_to_back: assert property (
        tx_state == frsp_pkg::TX_SHIFT && hold_full && ticks.os_tick &&
        tx_os == frsp_pkg::OS_LAST && tx_bit == frsp_pkg::TX_LAST_BIT
        |=> tx_state == frsp_pkg::TX_SHIFT && !tx_line && tx_bit == 4'h0)
        else $error("gap between back to back characters");
    a_error_summary: assert property (
        system_status[frsp_pkg::ST_RE] ==
        |system_status[frsp_pkg::ST_OE:frsp_pkg::ST_PE])
        else $error("error summary is not the OR of error bits");
    a_ready_on_done: assert property (
        rx_done |=> dr ##1 system_status[frsp_pkg::ST_DR])
        else $error("data ready did not rise after a character");
    a_read_clears: assert property (
        rx_buf_rd && !rx_done |=> !dr && !oe && !fe && !pe
            && serial_receive_buffer == {8'h00, $past(rx_buf)})
        else $error("receive read did not clear flags or return data");
    a_overrun_set: assert property (
        rx_done && dr && !rx_buf_rd |=> oe && rx_buf == $past(rx_sh[8:1]))
        else $error("overrun not flagged or buffer not replaced");
    a_console_bit: assert property (
        ##1 system_status[frsp_pkg::ST_CONSOLE] == $past(console_request))
        else $error("console bit does not follow the input");
    a_tx_idle_high: assert property (
        tx_state == frsp_pkg::TX_IDLE && !hold_full |=> serial_tx)
        else $error("idle line not high");
endmodule
`default_nettype wire

// [rtl/frsp_pkg.sv]
// Shared constants and types for the fixed rate serial port
package frsp_pkg;
    // ============================================================
    // Line format
    localparam int BAUD_RATE = 9600;
    localparam int OVERSAMPLE = 16;
    localparam int DATA_BITS = 8;
    localparam int CLK_HZ = 100_000_000;
    localparam int TIMER_CLK_HZ_DEF = 1_536_000;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] TX_LAST_BIT = 4'hA;
    localparam logic [3:0] RX_LAST_BIT = 4'h9;
    // ============================================================
    // System status bit positions
    localparam int ST_DR = 0;
    localparam int ST_TE = 1;
    localparam int ST_TBE = 2;
    localparam int ST_CONSOLE = 3;
    localparam int ST_PE = 4;
    localparam int ST_FE = 5;
    localparam int ST_OE = 6;
    localparam int ST_RE = 7;
    localparam logic [15:0] STATUS_RST = 16'h0006;
    localparam logic [15:0] RXBUF_RST = 16'h0000;
    // ============================================================
    // State machines
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } frsp_tx_e;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } frsp_rx_e;
endpackage

// [rtl/frsp_tick_if.sv]
// Rate ticks passed from the divider to the serial port core
`timescale 1ns/1ps
`default_nettype none
interface frsp_tick_if;
    logic os_tick;
    logic timer_tick;
    modport src (output os_tick, output timer_tick);
    modport dst (input os_tick, input timer_tick);
endinterface
`default_nettype wire

// [rtl/frsp_rate_div.sv]
// Divider turning the timer rate input into oversample and timer ticks
`timescale 1ns/1ps
`default_nettype none
module frsp_rate_div #(
    parameter int TIMER_CLK_HZ = frsp_pkg::TIMER_CLK_HZ_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Timer rate input
    input wire logic timer_rate_clock_in,
    // Ticks
    frsp_tick_if.src ticks
);
    localparam int DIV = TIMER_CLK_HZ /
        (frsp_pkg::BAUD_RATE * frsp_pkg::OVERSAMPLE);
    localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

    // The timer input must be slow enough to see both of its levels
    if (DIV < 1 || DIV > 65536 ||
        TIMER_CLK_HZ * 2 > frsp_pkg::CLK_HZ) begin : g_bad_rate
        $error("frsp_rate_div: unusable timer clock rate");
    end

    logic rate_q;
    logic [15:0] cnt;
    logic os_q;
    logic tm_q;
    logic next_rate_q;
    logic [15:0] next_cnt;
    logic next_os_q;
    logic next_tm_q;
    logic rise;

    // ============================================================
    // Edge count
    always_comb begin
        rise = timer_rate_clock_in & ~rate_q;
        next_rate_q = timer_rate_clock_in;
        next_tm_q = rise;
        next_os_q = 1'b0;
        next_cnt = cnt;
        if (rise) begin
            if (cnt == DIV_LAST) begin
                next_cnt = 16'h0000;
                next_os_q = 1'b1;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_q <= 1'b0;
            cnt <= 16'h0000;
            os_q <= 1'b0;
            tm_q <= 1'b0;
        end else begin
            rate_q <= next_rate_q;
            cnt <= next_cnt;
            os_q <= next_os_q;
            tm_q <= next_tm_q;
        end
    end

    assign ticks.os_tick = os_q;
    assign ticks.timer_tick = tm_q;
endmodule
`default_nettype wire

// [tb/frsp_console_model.sv]
// Console terminal model: sends characters and decodes transmitted frames
`timescale 1ns/1ps
`default_nettype none
module frsp_console_model #(
    parameter int BIT_CYC = 32
) (
    // Clock
    input wire logic clk,
    // Serial pins seen from the terminal
    input wire logic serial_tx,
    output logic serial_rx
);
    logic [7:0] got_q[$];
    logic got_err_q[$];
    time start_q[$];
    logic [10:0] frame;

    // Line idles at mark, as a terminal holds it between characters
    initial serial_rx = 1'b1;

    // ============================================================
    // Sender; the error knobs only serve the receive error tests
    task automatic send_char(input logic [7:0] d, input logic bad_par,
                             input logic bad_stop);
        logic [10:0] f;
        f = {~bad_stop, ~^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            serial_rx <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk);
        serial_rx <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask

    // ============================================================
    // Receiver: samples mid-bit, keeps byte, format error and start time
    initial begin
        forever begin
            @(negedge serial_tx);
            start_q.push_back($time);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 11; i++) begin
                frame[i] = serial_tx;
                if (i < 10) begin
                    repeat (BIT_CYC) @(posedge clk);
                end
            end
            got_q.push_back(frame[8:1]);
            got_err_q.push_back(frame[0] | ~frame[10] | ~^frame[9:1]);
        end
    end
endmodule
`default_nettype wire

// [tb/test_fixed_rate_serial_port.sv]
// Self-checking testbench for the fixed rate serial port
`timescale 1ns/1ps
`default_nettype none
module test_fixed_rate_serial_port;
    localparam int BIT_CYC = 32;
    logic clk;
    logic sys_rst;
    logic timer_rate_clock_in;
    logic interval_timer_tick;
    logic tx_buf_wr;
    logic [15:0] tx_buf_wdata;
    logic rx_buf_rd;
    logic [15:0] serial_receive_buffer;
    logic [15:0] system_status;
    logic console_request;
    logic serial_rx;
    logic serial_tx;
    int fail_count;
    int total_checks;
    int n;
    int c;
    logic [15:0] w[3];
    logic [7:0] d;

    // Divisor one keeps a frame at 352 cycles instead of 3520
    frsp_serial_port #(.TIMER_CLK_HZ(153600)) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .timer_rate_clock_in(timer_rate_clock_in),
        .interval_timer_tick(interval_timer_tick),
        .tx_buf_wr(tx_buf_wr),
        .tx_buf_wdata(tx_buf_wdata),
        .rx_buf_rd(rx_buf_rd),
        .serial_receive_buffer(serial_receive_buffer),
        .system_status(system_status),
        .console_request(console_request),
        .serial_rx(serial_rx),
        .serial_tx(serial_tx)
    );

    frsp_console_model #(.BIT_CYC(BIT_CYC)) u_con (
        .clk(clk),
        .serial_tx(serial_tx),
        .serial_rx(serial_rx)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Rate input toggles every cycle: one rising edge per two cycles
    always @(posedge clk) begin
        timer_rate_clock_in <= ~timer_rate_clock_in;
    end

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_bit(input int idx, input logic val, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge clk);
            #1;
            if (system_status[idx] === val) break;
        end
        chk({15'h0000, i < bound}, 16'h0001, "status wait");
        if (i == bound) close_out;
    endtask

    task automatic tx_write(input logic [15:0] v);
        @(posedge clk);
        tx_buf_wr <= 1'b1;
        tx_buf_wdata <= v;
        @(posedge clk);
        tx_buf_wr <= 1'b0;
        tx_buf_wdata <= ~v;
    endtask

    task automatic rx_read(input logic [7:0] e);
        @(posedge clk);
        rx_buf_rd <= 1'b1;
        @(posedge clk);
        rx_buf_rd <= 1'b0;
        #1;
        chk(serial_receive_buffer, {8'h00, e}, "rx data");
        @(posedge clk);
        #1;
        chk(system_status & 16'h00F1, 16'h0000, "rx flags clear");
    endtask

    function automatic logic [15:0] rx_status(input logic pe,
                                              input logic fe,
                                              input logic oe);
        return {8'h00, pe | fe | oe, oe, fe, pe, 3'h0, 1'h1};
    endfunction

    // ============================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        timer_rate_clock_in = 1'b0;
        tx_buf_wr = 1'b0;
        tx_buf_wdata = 16'h0000;
        rx_buf_rd = 1'b0;
        console_request = 1'b0;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(32'h165A125E));
        repeat (5) @(posedge clk);
        #1;
        chk(system_status, 16'h0006, "reset status");
        chk({15'h0000, serial_tx}, 16'h0001, "reset line");
        chk(serial_receive_buffer, 16'h0000, "reset rx");
        @(posedge clk);
        sys_rst <= 1'b0;
        $display("test reset done");

        // Let the divider pipeline settle so the tick pattern is steady
        repeat (4) @(posedge clk);
        n = 0;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk);
            #1;
            n += interval_timer_tick;
        end
        chk(16'(n), 16'h0064, "timer ticks");
        $display("test timer done");

        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            console_request <= 1'($urandom);
            repeat (3) @(posedge clk);
            #1;
            c = frsp_pkg::ST_CONSOLE;
            chk({15'h0000, system_status[c]}, {15'h0000, console_request},
                "console bit");
        end
        $display("test console done");

        for (int k = 0; k < 3; k++) w[k] = 16'($urandom);
        tx_write(w[0]);
        wait_bit(frsp_pkg::ST_TBE, 1'b0, 4);
        wait_bit(frsp_pkg::ST_TBE, 1'b1, 4);
        c = frsp_pkg::ST_TE;
        chk({15'h0000, system_status[c]}, 16'h0000, "shifter busy");
        tx_write(w[1]);
        repeat (3) @(posedge clk);
        #1;
        c = frsp_pkg::ST_TBE;
        chk({15'h0000, system_status[c]}, 16'h0000, "buffer full");
        // Write into a full holding buffer must be dropped
        tx_write(w[2]);
        wait_bit(frsp_pkg::ST_TE, 1'b1, 30 * BIT_CYC);
        repeat (BIT_CYC) @(posedge clk);
        chk(16'(u_con.start_q.size()), 16'h0002, "frame count");
        chk({8'h00, u_con.got_q[0]}, {8'h00, w[0][7:0]}, "char 0");
        chk({8'h00, u_con.got_q[1]}, {8'h00, w[1][7:0]}, "char 1");
        chk(16'(u_con.start_q[1] - u_con.start_q[0]), 16'(11 * BIT_CYC * 10),
            "frame gap");
        chk({15'h0000, u_con.got_err_q[0] | u_con.got_err_q[1]}, 16'h0000,
            "frame format");
        $display("test transmit done");

        // Cases by k mod 4: clean, parity, framing, overrun
        for (int k = 0; k < 8; k++) begin
            d = 8'($urandom);
            if (k % 4 == 3) begin
                u_con.send_char(~d, 1'b0, 1'b0);
            end
            u_con.send_char(d, k % 4 == 1, k % 4 == 2);
            wait_bit(frsp_pkg::ST_DR, 1'b1, 2 * BIT_CYC);
            chk(system_status & 16'h00F1,
                rx_status(k % 4 == 1, k % 4 == 2, k % 4 == 3),
                "rx status");
            rx_read(d);
        end
        $display("test receive done");
        close_out;
    end

    initial begin
        #200000;
        fail_count++;
        $display("unexpected at %0t: run too long", $time);
        close_out;
    end
endmodule
`default_nettype wire
